// >>> hdl/mta_regs.svh
// mta_regs.svh: offsets-free constants for the five-channel timer block
// assumes inclusion by bare name from hdl/ sources; definitions only
`ifndef MTA_REGS_SVH
`define MTA_REGS_SVH

// channel count and counter width
`define MTA_NCH 5
`define MTA_CNT_W 16

// counter landmarks
`define MTA_CNT_MAX 16'hFFFF
`define MTA_CNT_ONE 16'h0001
`define MTA_CNT_ZERO 16'h0000

// pwm cycle end positions: period minus one, 2^16-1 and 2^8-1 periods
`define MTA_PWM16_LAST 16'hFFFE
`define MTA_PWM8_LAST 16'h00FE

// 8-bit pwm field positions inside the counter word
`define MTA_PWM8_HI_MSB 15
`define MTA_PWM8_HI_LSB 8
`define MTA_PWM8_LO_MSB 7
`define MTA_PWM8_LO_LSB 0

// prescaler taps
`define MTA_DIV8_MASK 5'h07
`define MTA_DIV32_MASK 5'h1F

// channels that can count two-phase signals (2, 3, 4)
`define MTA_TWO_PHASE_MASK 5'h1C

`endif

// >>> hdl/mta_pkg.sv
// mta_pkg: types shared by the timer block and its bench
// assumes nothing beyond a SystemVerilog compiler
package mta_pkg;

  // operating mode, two low bits of the mode field
  typedef enum logic [1:0] {
    MTA_MODE_TIMER = 2'b00,
    MTA_MODE_EVENT = 2'b01,
    MTA_MODE_ONESHOT = 2'b10,
    MTA_MODE_PWM = 2'b11
  } mta_mode_t;

  // internal count source
  typedef enum logic [1:0] {
    MTA_CLK_F1 = 2'b00,
    MTA_CLK_F8 = 2'b01,
    MTA_CLK_F32 = 2'b10,
    MTA_CLK_SUBCLOCK_DIV_THIRTY_TWO = 2'b11
  } mta_clk_t;

  // event source / trigger source
  typedef enum logic [1:0] {
    MTA_SRC_PIN = 2'b00,
    MTA_SRC_TB2 = 2'b01,
    MTA_SRC_NEIGH = 2'b10,
    MTA_SRC_NONE = 2'b11
  } mta_src_t;

endpackage

// >>> hdl/mta_edge_if.sv
// mta_edge_if: filtered level and edge pulses of one synchronised pin
// assumes driver and reader share ref_clk_i
interface mta_edge_if;
  logic lvl;
  logic rise;
  logic fall;
  modport drv (output lvl, output rise, output fall);
  modport rcv (input lvl, input rise, input fall);
endinterface

// >>> hdl/mta_sync.sv
// mta_sync: three-flop pin synchroniser with agreement filter and edges
// assumes raw_i is asynchronous to ref_clk_i
module mta_sync (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // raw pin
  input wire logic raw_i,
  // filtered result
  mta_edge_if.drv edge_o
);

  logic s1_q, s2_q, s3_q;
  logic lvl_q, rise_q, fall_q;

  // plain shift chain; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce_i) begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level moves only when stages two and three agree
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (ce_i) begin
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
        rise_q <= s3_q & ~lvl_q;
        fall_q <= ~s3_q & lvl_q;
      end else begin
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end
    end
  end

  assign edge_o.lvl = lvl_q;
  assign edge_o.rise = rise_q;
  assign edge_o.fall = fall_q;

endmodule

// >>> hdl/mta_top.sv
// mta_top: five independent 16-bit multifunction timer channels
// assumes control bits come from logic on ref_clk_i; pins are asynchronous
`include "mta_regs.svh"

// Functional notes
// - five independent channels, each with its own 16-bit counter
// - mode field picks timer, event counter, one-shot or pwm
// - internal modes count undivided, div 8, div 32 or subclock div 32
// - timer mode counts down, reloads on underflow, requests interrupt
// - timer and event modes run while count start flag is one
// - write while stopped loads reload and counter; while running only reload
// - timer gate: input pin level enables counting
// - timer pulse output toggles output pin at each underflow
// - timer and event modes expose the live count
// - channels 0,1 single-phase only; 2 to 4 add two-phase counting
// - single-phase source: input pin edge, timer b two, or neighbour overflow
// - direction from software or from the output pin level
// - event mode requests interrupt on overflow or underflow
// - event mode reloads on wrap unless free-run is selected
// - event pulse output toggles output pin at each wrap
// - two-phase normal: input rise up, fall down, only while output high
// - multiply-by-4: every edge of both pins counts, direction by phase
// - one-shot counts down, reloads and stops at zero, retriggers
// - one-shot starts by trigger, overflow or start flag; stops on flag clear
// - one-shot lasts n source periods, interrupt when count ends
// - one-shot and pwm count readback carries no defined meaning
// - pwm emits a continuous pulse train, 16-bit or 8-bit
// - pwm counts down, reloads at each rising edge, ignores retriggers
// - 16-bit pwm: high n periods, cycle 2^16-1 periods
// - 8-bit pwm: low byte prescales, high byte sets width
module mta_top #(
  parameter int NCH = `MTA_NCH,
  parameter logic [NCH-1:0] TWO_PHASE_MASK = NCH'(`MTA_TWO_PHASE_MASK)
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // per-channel configuration
  input wire mta_pkg::mta_mode_t mode_i [NCH],
  input wire mta_pkg::mta_clk_t clk_sel_i [NCH],
  input wire mta_pkg::mta_src_t src_sel_i [NCH],
  input wire logic [NCH-1:0] gate_en_i,
  input wire logic [NCH-1:0] gate_high_i,
  input wire logic [NCH-1:0] pulse_out_en_i,
  input wire logic [NCH-1:0] rise_edge_i,
  input wire logic [NCH-1:0] updown_ext_i,
  input wire logic [NCH-1:0] count_up_i,
  input wire logic [NCH-1:0] free_run_i,
  input wire logic [NCH-1:0] two_phase_i,
  input wire logic [NCH-1:0] mul4_i,
  input wire logic [NCH-1:0] pwm8_i,
  // per-channel run control and counter write
  input wire logic [NCH-1:0] count_start_i,
  input wire logic [NCH-1:0] one_shot_start_i,
  input wire logic [NCH-1:0] wr_stb_i,
  input wire logic [NCH-1:0][15:0] wr_data_i,
  // external sources
  input wire logic [NCH-1:0] channel_input_pin_i,
  input wire logic [NCH-1:0] channel_output_pin_i,
  input wire logic timer_b_channel_two_ovf_i,
  input wire logic subclock_i,
  // results
  output logic [NCH-1:0][15:0] count_o,
  output logic [NCH-1:0] irq_o,
  output logic [NCH-1:0] channel_output_pin_o,
  output logic [NCH-1:0] channel_output_pin_oe_o
);
  import mta_pkg::*;

  logic [4:0] pre_div_q;
  logic [4:0] sub_div_q;
  logic tick_f8, tick_f32, tick_subclock_div_thirty_two;
  logic [NCH-1:0] irq_q;

  mta_edge_if sub_e ();

  // shared prescaler for the divided peripheral clocks
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_div_q <= 5'h00;
    end else if (ce_i) begin
      pre_div_q <= pre_div_q + 5'h01;
    end
  end

  assign tick_f8 = (pre_div_q & `MTA_DIV8_MASK) == `MTA_DIV8_MASK;
  assign tick_f32 = pre_div_q == `MTA_DIV32_MASK;

  // subclock arrives from another oscillator, so it is synchronised first
  mta_sync u_sub_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .raw_i(subclock_i),
    .edge_o(sub_e)
  );

  // subclock divided by 32; subclock must stay well below ref_clk_i / 4
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sub_div_q <= 5'h00;
    end else if (ce_i && sub_e.rise) begin
      sub_div_q <= sub_div_q + 5'h01;
    end
  end

  assign tick_subclock_div_thirty_two = sub_e.rise & (sub_div_q == `MTA_DIV32_MASK);
  assign irq_o = irq_q;

  // one independent copy of the channel per index
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int J = (i == 0) ? NCH - 1 : i - 1;
    localparam bit HAS_TWO = TWO_PHASE_MASK[i];

    mta_edge_if in_e ();
    mta_edge_if out_e ();

    logic [15:0] cnt_q, rld_q, cyc_q, width, pwm_last;
    logic [7:0] pre_q;
    logic act_q, tog_q, out_q, oe_q;
    logic tick_int, src_tick, pin_edge, ev_step, ev_up, q_up, q_dn, two;
    logic tmr_mode, ev_mode, os_mode, pwm_mode, counting, gate_ok, zero;
    logic timer_uf, ev_wrap, trig, start_os, os_done;
    logic pwm_tick, pwm_wrap, pwm_fall, start_pwm, irq_d;

    // both pins pass the synchroniser before edges are taken
    mta_sync u_in_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .raw_i(channel_input_pin_i[i]),
      .edge_o(in_e)
    );

    mta_sync u_out_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .raw_i(channel_output_pin_i[i]),
      .edge_o(out_e)
    );

    // mode decode from the two-bit field
    assign tmr_mode = mode_i[i] == MTA_MODE_TIMER;
    assign ev_mode = mode_i[i] == MTA_MODE_EVENT;
    assign os_mode = mode_i[i] == MTA_MODE_ONESHOT;
    assign pwm_mode = mode_i[i] == MTA_MODE_PWM;

    // internal count source select
    always_comb begin
      unique case (clk_sel_i[i])
        MTA_CLK_F1: tick_int = 1'b1;
        MTA_CLK_F8: tick_int = tick_f8;
        MTA_CLK_F32: tick_int = tick_f32;
        MTA_CLK_SUBCLOCK_DIV_THIRTY_TWO: tick_int = tick_subclock_div_thirty_two;
      endcase
    end

    // external source / trigger select; neighbour uses its registered request
    assign pin_edge = rise_edge_i[i] ? in_e.rise : in_e.fall;
    always_comb begin
      unique case (src_sel_i[i])
        MTA_SRC_PIN: src_tick = pin_edge;
        MTA_SRC_TB2: src_tick = timer_b_channel_two_ovf_i;
        MTA_SRC_NEIGH: src_tick = irq_q[J];
        default: src_tick = 1'b0;
      endcase
    end

    // two-phase decode exists only where the channel supports it
    assign two = HAS_TWO & two_phase_i[i];
    always_comb begin
      q_up = 1'b0;
      q_dn = 1'b0;
      if (mul4_i[i]) begin
        // every edge of both pins, direction from phase
        q_up = (in_e.rise & out_e.lvl) | (in_e.fall & ~out_e.lvl) |
               (out_e.rise & ~in_e.lvl) | (out_e.fall & in_e.lvl);
        q_dn = (in_e.fall & out_e.lvl) | (in_e.rise & ~out_e.lvl) |
               (out_e.fall & ~in_e.lvl) | (out_e.rise & in_e.lvl);
      end else begin
        // input edges count only while the output pin is high
        q_up = in_e.rise & out_e.lvl;
        q_dn = in_e.fall & out_e.lvl;
      end
    end

    // event step and direction; simultaneous up and down cancel
    always_comb begin
      if (two) begin
        ev_step = q_up ^ q_dn;
        ev_up = q_up;
      end else begin
        ev_step = src_tick;
        ev_up = updown_ext_i[i] ? out_e.lvl : count_up_i[i];
      end
    end

    // running flag decides where a counter write lands
    assign counting = (tmr_mode | ev_mode) ? count_start_i[i] : act_q;
    assign gate_ok = ~gate_en_i[i] | (in_e.lvl == gate_high_i[i]);
    assign zero = cnt_q == `MTA_CNT_ZERO;

    // wrap events: timer underflow and event overflow or underflow
    assign timer_uf = tmr_mode & count_start_i[i] & gate_ok & tick_int & zero;
    assign ev_wrap = ev_mode & count_start_i[i] & ev_step &
                     (ev_up ? (cnt_q == `MTA_CNT_MAX) : zero);

    // one-shot start: trigger or start flag, only with count start set
    assign trig = one_shot_start_i[i] | src_tick;
    assign start_os = os_mode & count_start_i[i] & trig;
    assign os_done = os_mode & act_q & tick_int & (cnt_q <= `MTA_CNT_ONE) & ~start_os;

    // pwm stepping; 8-bit form steps once per m+1 source periods
    assign pwm_tick = tick_int & (~pwm8_i[i] | (pre_q == 8'h00));
    assign pwm_last = pwm8_i[i] ? `MTA_PWM8_LAST : `MTA_PWM16_LAST;
    assign width = pwm8_i[i] ? {8'h00, rld_q[`MTA_PWM8_HI_MSB:`MTA_PWM8_HI_LSB]} : rld_q;
    assign start_pwm = pwm_mode & count_start_i[i] & ~act_q &
                       ((src_sel_i[i] == MTA_SRC_NONE) | src_tick);
    assign pwm_wrap = pwm_mode & act_q & pwm_tick & (cyc_q == pwm_last);
    assign pwm_fall = pwm_mode & act_q & pwm_tick & ~pwm_wrap & (cnt_q == `MTA_CNT_ONE);

    assign irq_d = timer_uf | ev_wrap | os_done | pwm_fall;

    // reload register takes every write
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rld_q <= `MTA_CNT_ZERO;
      end else if (ce_i && wr_stb_i[i]) begin
        rld_q <= wr_data_i[i];
      end
    end

    // main counter
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_q <= `MTA_CNT_ZERO;
      end else if (ce_i) begin
        if (wr_stb_i[i] && !counting) begin
          cnt_q <= wr_data_i[i];
        end else begin
          unique case (mode_i[i])
            MTA_MODE_TIMER: begin
              if (count_start_i[i] && gate_ok && tick_int) begin
                cnt_q <= zero ? rld_q : cnt_q - `MTA_CNT_ONE;
              end
            end
            MTA_MODE_EVENT: begin
              if (count_start_i[i] && ev_step) begin
                if (ev_wrap && !free_run_i[i]) begin
                  cnt_q <= rld_q;
                end else if (ev_up) begin
                  cnt_q <= cnt_q + `MTA_CNT_ONE;
                end else begin
                  cnt_q <= cnt_q - `MTA_CNT_ONE;
                end
              end
            end
            MTA_MODE_ONESHOT: begin
              if (start_os || os_done) begin
                cnt_q <= rld_q;
              end else if (act_q && tick_int) begin
                cnt_q <= cnt_q - `MTA_CNT_ONE;
              end
            end
            MTA_MODE_PWM: begin
              if (start_pwm || pwm_wrap) begin
                cnt_q <= width;
              end else if (act_q && pwm_tick && !zero) begin
                cnt_q <= cnt_q - `MTA_CNT_ONE;
              end
            end
          endcase
        end
      end
    end

    // active flag for one-shot and pwm; cleared with count start
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        act_q <= 1'b0;
      end else if (ce_i) begin
        if (!count_start_i[i] || tmr_mode || ev_mode) begin
          act_q <= 1'b0;
        end else if (os_mode) begin
          if (start_os) begin
            act_q <= 1'b1;
          end else if (os_done) begin
            act_q <= 1'b0;
          end
        end else if (start_pwm) begin
          act_q <= 1'b1;
        end
      end
    end

    // pwm cycle position; fixed period regardless of width
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cyc_q <= `MTA_CNT_ZERO;
      end else if (ce_i) begin
        if (start_pwm || pwm_wrap) begin
          cyc_q <= `MTA_CNT_ZERO;
        end else if (pwm_mode && act_q && pwm_tick) begin
          cyc_q <= cyc_q + `MTA_CNT_ONE;
        end
      end
    end

    // 8-bit pwm prescaler from the low byte
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pre_q <= 8'h00;
      end else if (ce_i) begin
        if (start_pwm || (pwm_mode && act_q && tick_int && pre_q == 8'h00)) begin
          pre_q <= rld_q[`MTA_PWM8_LO_MSB:`MTA_PWM8_LO_LSB];
        end else if (pwm_mode && act_q && tick_int) begin
          pre_q <= pre_q - 8'h01;
        end
      end
    end

    // toggle on each timer underflow or event wrap
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        tog_q <= 1'b0;
      end else if (ce_i && (timer_uf || ev_wrap)) begin
        tog_q <= ~tog_q;
      end
    end

    // output pin level and enable; the pin is an input when it steers direction
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        out_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (ce_i) begin
        unique case (mode_i[i])
          MTA_MODE_TIMER: out_q <= tog_q;
          MTA_MODE_EVENT: out_q <= tog_q;
          MTA_MODE_ONESHOT: out_q <= act_q;
          MTA_MODE_PWM: out_q <= act_q & ~zero;
        endcase
        oe_q <= pwm_mode | (pulse_out_en_i[i] & ~(ev_mode & (updown_ext_i[i] | two)));
      end
    end

    // one-cycle interrupt request
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        irq_q[i] <= 1'b0;
      end else if (ce_i) begin
        irq_q[i] <= irq_d;
      end
    end

    // live count readback; in one-shot and pwm it is internal scratch
    assign count_o[i] = cnt_q;
    assign channel_output_pin_o[i] = out_q;
    assign channel_output_pin_oe_o[i] = oe_q;
  end

endmodule

// >>> sim/mta_enc.sv
// mta_enc: two-phase encoder standing at one channel's in and out pins
// assumes step_i is a one-cycle pulse on the bench clock
module mta_enc (
  // clock and step request
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic dir_up_i,
  // encoder phases
  output logic phase_in_o,
  output logic phase_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos_q = 2'h0;
  // one quarter step per request; only one phase moves at a time
  always @(posedge clk_i) begin
    if (step_i) begin
      pos_q <= dir_up_i ? pos_q + 2'h1 : pos_q - 2'h1;
    end
  end
  // gray walk: moving up, the in phase rises while out is high
  assign phase_in_o = pos_q[1];
  assign phase_out_o = ^pos_q;
endmodule

// >>> sim/mta_top_chk.sv
// mta_chk: port checks on channel 0 timer, 1 one-shot and 3 pwm
// assumes the bench keeps those channel roles fixed
module mta_chk import mta_pkg::*; #(
  parameter int NCH = 5
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // configuration and control
  input wire mta_pkg::mta_mode_t mode_i [NCH],
  input wire mta_pkg::mta_clk_t clk_sel_i [NCH],
  input wire logic [NCH-1:0] gate_en_i,
  input wire logic [NCH-1:0] pulse_out_en_i,
  input wire logic [NCH-1:0] count_start_i,
  input wire logic [NCH-1:0] wr_stb_i,
  input wire logic [NCH-1:0][15:0] wr_data_i,
  // results
  input wire logic [NCH-1:0][15:0] count_o,
  input wire logic [NCH-1:0] irq_o,
  input wire logic [NCH-1:0] channel_output_pin_o,
  input wire logic [NCH-1:0] channel_output_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // channel 0 ticking every clock with no gate
  wire logic run0 = ce_i && mode_i[0] == MTA_MODE_TIMER && count_start_i[0] &&
    clk_sel_i[0] == MTA_CLK_F1 && !gate_en_i[0];
  wire logic idle0 = ce_i && mode_i[0] == MTA_MODE_TIMER && !count_start_i[0];
  a_load_stopped: assert property (idle0 && wr_stb_i[0] |=>
    count_o[0] == $past(wr_data_i[0])) else $error("stopped write not loaded");
  a_hold_stopped: assert property (idle0 && !wr_stb_i[0] |=> $stable(count_o[0]))
    else $error("stopped counter moved");
  a_timer_dec: assert property (run0 && count_o[0] != 16'h0000 |=>
    count_o[0] == $past(count_o[0]) - 16'h0001 && !irq_o[0])
    else $error("timer did not step down");
  a_timer_wrap: assert property (run0 && count_o[0] == 16'h0000 |=> irq_o[0])
    else $error("underflow without request");
  a_toggle_out: assert property (ce_i && irq_o[0] && mode_i[0] == MTA_MODE_TIMER &&
    pulse_out_en_i[0] |-> ##[0:2] $changed(channel_output_pin_o[0]))
    else $error("pulse output did not invert");
  a_shot_pulse: assert property (irq_o[1] |=> !irq_o[1])
    else $error("request longer than one cycle");
  a_pwm_drives: assert property (mode_i[3] == MTA_MODE_PWM [*3] |->
    channel_output_pin_oe_o[3]) else $error("pwm pin not driven");
  a_pwm_stop_low: assert property ((mode_i[3] == MTA_MODE_PWM && !count_start_i[3]) [*3]
    |-> !channel_output_pin_o[3]) else $error("stopped pwm still high");
  a_pwm_irq_fall: assert property (irq_o[3] |-> ##[0:2] $fell(channel_output_pin_o[3]))
    else $error("pwm request without falling pulse");
endmodule

bind mta_top mta_chk #(.NCH(NCH)) mta_chk_i (.ref_clk_i, .rst_n_i, .ce_i, .mode_i, .clk_sel_i,
  .gate_en_i, .pulse_out_en_i, .count_start_i, .wr_stb_i, .wr_data_i, .count_o, .irq_o,
  .channel_output_pin_o, .channel_output_pin_oe_o);

// >>> sim/mta_top_test.sv
// mta_top_test: self-checking bench for the five-channel timer block
// assumes mta_top with its bound checker and the mta_enc encoder model
module mta_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mta_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic subclock_i = 1'b0;
  logic [31:0] lfsr_q = 32'h3A7C;
  mta_mode_t mode_i [5];
  mta_clk_t clk_sel_i [5];
  mta_src_t src_sel_i [5];
  logic [4:0] gate_en_i, gate_high_i, rise_edge_i, updown_ext_i, count_up_i, free_run_i;
  logic [4:0] pulse_out_en_i, two_phase_i, mul4_i, pwm8_i, count_start_i;
  logic [4:0] one_shot_start_i, wr_stb_i;
  logic [4:0][15:0] wr_data_i = '0;
  logic enc_step = 1'b0;
  logic enc_up = 1'b1;
  logic enc_in;
  logic enc_out;
  logic [4:0][15:0] count_o;
  logic [4:0] irq_o;
  logic [4:0] channel_output_pin_o;
  logic [4:0] channel_output_pin_oe_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // spare channels see random pin noise; channel 2 faces the encoder
  wire logic [4:0] pin_in_w = {lfsr_q[9:8], enc_in, lfsr_q[1:0]};
  wire logic [4:0] pin_out_w = {lfsr_q[12:11], enc_out, lfsr_q[4:3]};

  mta_top mta_top_i (.ref_clk_i, .rst_n_i, .ce_i, .mode_i, .clk_sel_i, .src_sel_i, .gate_en_i,
    .gate_high_i, .pulse_out_en_i, .rise_edge_i, .updown_ext_i, .count_up_i, .free_run_i,
    .two_phase_i, .mul4_i, .pwm8_i, .count_start_i, .one_shot_start_i, .wr_stb_i, .wr_data_i,
    .channel_input_pin_i(pin_in_w), .channel_output_pin_i(pin_out_w),
    .timer_b_channel_two_ovf_i(lfsr_q[5] & lfsr_q[6]), .subclock_i, .count_o, .irq_o,
    .channel_output_pin_o, .channel_output_pin_oe_o);
  mta_enc mta_enc_i (.clk_i(ref_clk_i), .step_i(enc_step), .dir_up_i(enc_up),
    .phase_in_o(enc_in), .phase_out_o(enc_out));

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // counter write: strobe held through exactly one sampling edge
  task automatic wr(int ch, logic [15:0] d);
    wr_stb_i[ch] <= 1'b1;
    wr_data_i[ch] <= d;
    @(posedge ref_clk_i);
    wr_stb_i[ch] <= 1'b0;
  endtask

  // cycles until a request shows, sampled mid-cycle so edge updates have landed
  task automatic wait_irq(int ch, output int k);
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (irq_o[ch] !== 1'b1 && k < 70000);
  endtask

  task automatic wait_lvl(logic v, output int k);
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (channel_output_pin_o[3] !== v && k < 70000);
  endtask

  // one encoder quarter step, then time for the pin filters to settle
  task automatic step(logic up);
    enc_up <= up;
    enc_step <= 1'b1;
    @(posedge ref_clk_i);
    enc_step <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
  endtask

  task automatic shot();
    @(posedge ref_clk_i);
    one_shot_start_i[1] <= 1'b1;
    @(posedge ref_clk_i);
    one_shot_start_i[1] <= 1'b0;
  endtask

  // clocks: 25 MHz main, subclock below a quarter of it
  always #20 ref_clk_i = ~ref_clk_i;
  always #170 subclock_i = ~subclock_i;

  // random source and hang guard; ceiling covers one 16-bit pwm cycle with margin
  always @(posedge ref_clk_i) begin
    lfsr_q <= lfsr_next(lfsr_q);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    int k, n, hi, lo, div;
    logic o;
    foreach (mode_i[c]) begin
      mode_i[c] = MTA_MODE_TIMER;
      clk_sel_i[c] = MTA_CLK_F1;
      src_sel_i[c] = MTA_SRC_NONE;
    end
    mode_i[4] = mta_mode_t'(lfsr_q[3:2]);
    src_sel_i[4] = mta_src_t'(lfsr_q[5:4]);
    {gate_high_i, rise_edge_i, updown_ext_i, count_up_i, free_run_i} = lfsr_q[24:0];
    {gate_en_i, pulse_out_en_i, two_phase_i, mul4_i, pwm8_i} = {5{lfsr_q[14:10] & 5'h10}};
    {count_start_i, one_shot_start_i, wr_stb_i} = '0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // timer on channel 0: period for f1, f8 and f32 sources, pin inversion, write while running
    pulse_out_en_i[0] <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk_i);
      div = (s == 0) ? 1 : (s == 1) ? 8 : 32;
      n = int'(lfsr_q[2:0]) + 2;
      count_start_i[0] <= 1'b0;
      clk_sel_i[0] <= mta_clk_t'(s);
      wr(0, 16'(n));
      @(negedge ref_clk_i);
      chk("timer load", count_o[0], n); // stopped write reaches counter
      @(posedge ref_clk_i);
      count_start_i[0] <= 1'b1;
      wait_irq(0, k);
      o = channel_output_pin_o[0];
      wait_irq(0, k);
      chk("timer period", k, (n + 1) * div);
      chk("pulse pin", channel_output_pin_o[0], !o);
      @(posedge ref_clk_i);
      wr(0, 16'(n + 3));
      wait_irq(0, k);
      wait_irq(0, k);
      chk("reload after running write", k, (n + 4) * div);
    end
    $display("timer test done");
    // event counter on channel 1 fed by channel 0 underflows, software down count
    @(posedge ref_clk_i);
    mode_i[1] <= MTA_MODE_EVENT;
    src_sel_i[1] <= MTA_SRC_NEIGH;
    {updown_ext_i[1], count_up_i[1], free_run_i[1]} <= 3'b000;
    wr(1, 16'h0002);
    count_start_i[1] <= 1'b1;
    wait_irq(1, k);
    o = channel_output_pin_o[1];
    wait_irq(1, k);
    chk("event period", k, 3 * (n + 4) * div); // set value 2 down: three events
    chk("event pulse pin", channel_output_pin_o[1], !o);
    count_start_i[0] <= 1'b0;
    $display("event test done");
    // two-phase counting on channel 2: normal, then multiply-by-4
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk_i);
      mode_i[2] <= MTA_MODE_EVENT;
      two_phase_i[2] <= 1'b1;
      mul4_i[2] <= m[0];
      count_start_i[2] <= 1'b0;
      wr(2, 16'h0100);
      count_start_i[2] <= 1'b1;
      repeat (12) step(1'b1);
      repeat (4) step(1'b0);
      @(negedge ref_clk_i);
      chk("quadrature count", count_o[2], 16'h0100 + (m ? 8 : 2));
    end
    $display("two-phase test done");
    // one-shot on channel 1: length, retrigger, stop after the shot
    @(posedge ref_clk_i);
    mode_i[1] <= MTA_MODE_ONESHOT;
    src_sel_i[1] <= MTA_SRC_NONE;
    pulse_out_en_i[1] <= 1'b1;
    count_start_i[1] <= 1'b1;
    wr(1, 16'h0006);
    shot();
    wait_irq(1, k);
    chk("one-shot length", k, 7); // trigger edge plus six ticks
    shot();
    repeat (3) @(posedge ref_clk_i);
    shot();
    wait_irq(1, k);
    chk("retrigger length", k, 7);
    lo = 0;
    repeat (20) begin
      @(negedge ref_clk_i);
      lo += int'(irq_o[1] === 1'b1);
    end
    chk("one-shot stays stopped", lo, 0);
    $display("one-shot test done");
    // pwm on channel 3: 16-bit then 8-bit widths and cycles
    @(posedge ref_clk_i);
    mode_i[3] <= MTA_MODE_PWM;
    n = int'(lfsr_q[5:0]) + 4;
    wr(3, 16'(n));
    count_start_i[3] <= 1'b1;
    wait_lvl(1'b1, k);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    chk("pwm16 high", hi, n);
    chk("pwm16 cycle", hi + lo, 65535);
    @(posedge ref_clk_i);
    count_start_i[3] <= 1'b0;
    pwm8_i[3] <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    wr(3, 16'h0302);
    count_start_i[3] <= 1'b1;
    wait_lvl(1'b1, k);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    chk("pwm8 high", hi, 9); // width times prescale
    chk("pwm8 cycle", hi + lo, 765);
    $display("pwm test done");
    wrap_up();
  end
endmodule
